// [src/ctm_top.sv]
// compact timer module: counter, comparators, byte port, pins
`timescale 1ns/100ps
`default_nettype none
module ctm_top
  import ctm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire ctm_bus_t bus_in,
  output logic [7:0] rdata_out,
  input wire logic tick_high_in,
  input wire logic tick_sub_in,
  input wire logic external_clock_input_in,
  input wire logic invert_zero_in,
  input wire logic invert_one_in,
  output logic timer_output_zero_out,
  output logic timer_output_one_out,
  output logic irq_compare_a_out,
  output logic irq_compare_p_out
);

  // last count before a period match
  // code zero runs the full ten bits
  function automatic logic [9:0] per_last(input logic [2:0] code);
    if (code == 3'h0) begin
      per_last = CNT_TOP;
    end else begin
      per_last = {code, 7'h00} - 10'h001;
    end
  endfunction

  // reset release flops
  logic rst_meta_q;
  logic rst_n;

  // registered state and its next value
  ctm_state_t st_q;
  ctm_state_t st_d;

  // decoded control fields
  logic on_q; // counter enabled
  logic pause_q; // counter frozen
  logic [2:0] clk_sel; // clock source
  logic [2:0] period; // comparator P code
  ctm_mode_t mode; // operating mode
  ctm_act_t act; // output action
  logic cclr; // clear on compare A

  // step terms
  logic tick; // one counter clock
  logic p_match; // period reached
  logic a_match; // compare A reached
  logic ovf; // top reached
  logic pwm_on; // pwm active phase
  logic [9:0] duty; // pwm duty value

  assign on_q = st_q.ctl0[C0_ON];
  assign pause_q = st_q.ctl0[C0_PAUSE];
  assign clk_sel = st_q.ctl0[C0_CLK_HI:C0_CLK_LO];
  assign period = st_q.ctl0[C0_PER_HI:C0_PER_LO];
  assign mode = ctm_mode_t'(st_q.ctl1[C1_MODE_HI:C1_MODE_LO]);
  assign act = ctm_act_t'(st_q.ctl1[C1_ACT_HI:C1_ACT_LO]);
  assign cclr = st_q.ctl1[C1_CCLR];

  // outputs straight from flops
  assign rdata_out = st_q.rdata;
  assign timer_output_zero_out = st_q.pin0;
  assign timer_output_one_out = st_q.pin1;
  assign irq_compare_a_out = st_q.irq_a;
  assign irq_compare_p_out = st_q.irq_p;

  // reset release through two flops
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // counter clock selection
  // external edges come from the second sync flop onward
  always_comb begin
    unique case (clk_sel)
      CLK_SYS4: begin
        tick = (st_q.div_sys == DIV_SYS_LAST);
      end
      CLK_SYS: begin
        tick = 1'b1;
      end
      CLK_H16: begin
        tick = tick_high_in && (st_q.div_high[3:0] == DIV_H16_LAST);
      end
      CLK_H64: begin
        tick = tick_high_in && (st_q.div_high == DIV_H64_LAST);
      end
      CLK_SUB0, CLK_SUB1: begin
        tick = tick_sub_in;
      end
      CLK_EXT_RISE: begin
        tick = st_q.ext_sync[1] && !st_q.ext_sync[2];
      end
      CLK_EXT_FALL: begin
        tick = !st_q.ext_sync[1] && st_q.ext_sync[2];
      end
    endcase
  end

  // comparators look at the value being left
  assign p_match = (st_q.cnt == per_last(period));
  assign a_match = (st_q.cnt == st_q.cmp - 10'h001);
  assign ovf = (st_q.cnt == CNT_TOP);

  // pwm: duty from compare A, or from period when swapped
  assign duty = st_q.ctl1[C1_SWAP] ? {period, 7'h00} : st_q.cmp;
  assign pwm_on = (st_q.cnt < duty);

  // next state
  always_comb begin
    st_d = st_q;
    // request pulses last one cycle
    st_d.irq_a = 1'b0;
    st_d.irq_p = 1'b0;
    // read data stands one cycle only
    st_d.rdata = 8'h00;
    // pin sampling chain
    st_d.ext_sync = {st_q.ext_sync[1:0], external_clock_input_in};
    // free running dividers
    st_d.div_sys = st_q.div_sys + 2'h1;
    if (tick_high_in) begin
      st_d.div_high = st_q.div_high + 6'h01;
    end

    // counting: off or paused holds the value
    if (on_q && !pause_q && tick) begin
      if (ovf || (!cclr && p_match) || (cclr && a_match)) begin
        st_d.cnt = RST_CNT;
      end else begin
        st_d.cnt = st_q.cnt + 10'h001;
      end
      // separate request pulses
      st_d.irq_a = a_match;
      st_d.irq_p = p_match || ovf;
      // compare output action on compare A
      if (mode == MODE_CMP && a_match) begin
        unique case (act)
          ACT_NONE: begin
            st_d.out_lvl = st_q.out_lvl;
          end
          ACT_LOW: begin
            st_d.out_lvl = 1'b0;
          end
          ACT_HIGH: begin
            st_d.out_lvl = 1'b1;
          end
          ACT_TOGGLE: begin
            st_d.out_lvl = !st_q.out_lvl;
          end
        endcase
      end
    end

    // pwm output set each cycle: follows the counter with action high, fixed level otherwise
    if (mode == MODE_PWM) begin
      unique case (act)
        ACT_NONE: begin
          st_d.out_lvl = 1'b0;
        end
        ACT_LOW: begin
          st_d.out_lvl = 1'b1;
        end
        ACT_HIGH: begin
          st_d.out_lvl = pwm_on;
        end
        ACT_TOGGLE: begin
          // undefined code parks the output inactive
          st_d.out_lvl = 1'b0;
        end
      endcase
    end
    // timer mode and the undefined code leave the output alone

    // register writes; counter pair has no write path
    if (bus_in.wr) begin
      unique case (bus_in.addr)
        OFS_CTL0: begin
          st_d.ctl0 = bus_in.wdata;
          // rising on bit: clear, restore initial level in compare mode
          if (!on_q && bus_in.wdata[C0_ON]) begin
            st_d.cnt = RST_CNT;
            if (mode == MODE_CMP) begin
              st_d.out_lvl = st_q.ctl1[C1_INIT];
            end
          end
        end
        OFS_CTL1: begin
          st_d.ctl1 = bus_in.wdata;
        end
        OFS_CMPL: begin
          st_d.hold = bus_in.wdata;
        end
        OFS_CMPH: begin
          st_d.cmp = {bus_in.wdata[1:0], st_q.hold};
        end
        default: begin
          // counter bytes and free codes ignore writes
          st_d.hold = st_q.hold;
        end
      endcase
    end

    // register reads; high reads load the buffer
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        OFS_CTL0: begin
          st_d.rdata = st_q.ctl0;
        end
        OFS_CTL1: begin
          st_d.rdata = st_q.ctl1;
        end
        OFS_CNTL, OFS_CMPL: begin
          st_d.rdata = st_q.hold;
        end
        OFS_CNTH: begin
          st_d.rdata = {6'h00, st_q.cnt[9:8]};
          st_d.hold = st_q.cnt[7:0];
        end
        OFS_CMPH: begin
          st_d.rdata = {6'h00, st_q.cmp[9:8]};
          st_d.hold = st_q.cmp[7:0];
        end
        default: begin
          // unmapped codes read zero
          st_d.rdata = 8'h00;
        end
      endcase
    end

    // pins: shared level, each inverted by its port bit
    st_d.pin0 = st_d.out_lvl ^ st_d.ctl1[C1_POL] ^ invert_zero_in;
    st_d.pin1 = st_d.out_lvl ^ st_d.ctl1[C1_POL] ^ invert_one_in;
  end

  // state register
  always_ff @(posedge clk_sys_in or negedge rst_n) begin
    if (!rst_n) begin
      st_q.ctl0 <= RST_CTL0;
      st_q.ctl1 <= RST_CTL1;
      st_q.cnt <= RST_CNT;
      st_q.cmp <= RST_CMP;
      st_q.hold <= RST_HOLD;
      st_q.rdata <= 8'h00;
      st_q.div_sys <= 2'h0;
      st_q.div_high <= 6'h00;
      st_q.ext_sync <= 3'h0;
      st_q.out_lvl <= 1'b0;
      st_q.pin0 <= 1'b0;
      st_q.pin1 <= 1'b0;
      st_q.irq_a <= 1'b0;
      st_q.irq_p <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // low write touches only the buffer
  AST_LOW_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    bus_in.wr && bus_in.addr == OFS_CMPL |=>
      $stable(st_q.cmp) && st_q.hold == $past(bus_in.wdata))
    else $error("compare low write changed compare value");

  // high write joins new high bits with buffered low
  AST_HIGH_WRITE: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    bus_in.wr && bus_in.addr == OFS_CMPH |=>
      st_q.cmp == {$past(bus_in.wdata[1:0]), $past(st_q.hold)})
    else $error("compare high write did not latch buffer");

  // high read of counter: zero-padded bits and buffer capture
  AST_HIGH_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    bus_in.rd && bus_in.addr == OFS_CNTH |=>
      rdata_out == {6'h00, $past(st_q.cnt[9:8])} &&
      st_q.hold == $past(st_q.cnt[7:0]))
    else $error("counter high read wrong");

  // low reads come from the buffer
  AST_LOW_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    bus_in.rd && (bus_in.addr == OFS_CNTL || bus_in.addr == OFS_CMPL) |=>
      rdata_out == $past(st_q.hold))
    else $error("low byte read not from buffer");

  // switching on starts from zero
  AST_ON_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    $rose(on_q) |-> st_q.cnt == RST_CNT)
    else $error("counter not cleared on switch on");

  // off keeps the count
  AST_OFF_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    !on_q ##1 !on_q |-> $stable(st_q.cnt))
    else $error("counter moved while off");

  // pause keeps the count
  AST_PAUSE_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    (on_q && pause_q) ##1 (on_q && pause_q) |-> $stable(st_q.cnt))
    else $error("counter moved while paused");

  // period request only at the period end or the top
  AST_PERIOD_END: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    irq_compare_p_out |->
      $past(st_q.cnt) == per_last($past(period)) || $past(st_q.cnt) == CNT_TOP)
    else $error("period request at wrong count");

  // period match with clear select zero restarts the count
  AST_PERIOD_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    irq_compare_p_out && !$past(cclr) |-> st_q.cnt == RST_CNT)
    else $error("period match did not clear counter");

  // switching on in compare mode restores initial level
  AST_INIT_LEVEL: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    $rose(on_q) && $past(mode) == MODE_CMP |->
      st_q.out_lvl == $past(st_q.ctl1[C1_INIT]))
    else $error("output not at initial level");

  // buffer moves only on a low write or a high read
  AST_HOLD_STILL: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    !(bus_in.wr && bus_in.addr == OFS_CMPL) &&
      !(bus_in.rd && (bus_in.addr == OFS_CNTH || bus_in.addr == OFS_CMPH)) |=>
      $stable(st_q.hold))
    else $error("low byte buffer moved without high access");

  // high read of compare A: zero-padded bits and buffer capture
  AST_CMP_HIGH_READ: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    bus_in.rd && bus_in.addr == OFS_CMPH |=>
      rdata_out == {6'h00, $past(st_q.cmp[9:8])} &&
      st_q.hold == $past(st_q.cmp[7:0]))
    else $error("compare high read wrong");

  // unused high byte bits always read zero
  AST_HIGH_ZERO: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    bus_in.rd && (bus_in.addr == OFS_CNTH || bus_in.addr == OFS_CMPH) |=>
      rdata_out[7:2] == 6'h00)
    else $error("unused high byte bits not zero");

  // a plain tick advances the count by one
  AST_COUNT_STEP: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    on_q && !pause_q && tick && !ovf && !p_match && !a_match |=>
      st_q.cnt == $past(st_q.cnt) + 10'h001)
    else $error("counter did not step by one");

  // no selected tick, no switch-on write: count stands
  AST_IDLE_HOLD: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    !(on_q && !pause_q && tick) && !(bus_in.wr && bus_in.addr == OFS_CTL0) |=>
      $stable(st_q.cnt))
    else $error("counter moved without a tick");

  // top of count wraps to zero with a period request
  AST_TOP_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    on_q && !pause_q && tick && ovf |=>
      st_q.cnt == RST_CNT && irq_compare_p_out)
    else $error("overflow did not clear counter");

  // compare A match with clear select set restarts the count
  AST_A_CLEAR: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    on_q && !pause_q && tick && cclr && a_match |=>
      st_q.cnt == RST_CNT && irq_compare_a_out)
    else $error("compare match did not clear counter");

  // compare A request only after a counted match
  AST_A_PULSE: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    irq_compare_a_out |->
      $past(on_q && !pause_q && tick && a_match))
    else $error("compare request without a match");

  // pins differ exactly where the port bits differ; skips the reset edge
  AST_PIN_PAIR: assert property (@(posedge clk_sys_in) disable iff (!rst_n)
    $past(rst_n) |->
      (timer_output_zero_out ^ timer_output_one_out) == $past(invert_zero_in ^ invert_one_in))
    else $error("output pins not paired as selected");

endmodule
`default_nettype wire

// [inc/ctm_pkg.sv]
// constants and carrier types of the compact timer module
`default_nettype none
package ctm_pkg;
  // register offsets on the plain port
  localparam logic [2:0] OFS_CTL0 = 3'h0;
  localparam logic [2:0] OFS_CTL1 = 3'h1;
  localparam logic [2:0] OFS_CNTL = 3'h2;
  localparam logic [2:0] OFS_CNTH = 3'h3;
  localparam logic [2:0] OFS_CMPL = 3'h4;
  localparam logic [2:0] OFS_CMPH = 3'h5;
  // control zero fields
  localparam int C0_PAUSE = 7;
  localparam int C0_CLK_HI = 6;
  localparam int C0_CLK_LO = 4;
  localparam int C0_ON = 3;
  localparam int C0_PER_HI = 2;
  localparam int C0_PER_LO = 0;
  // control one fields
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_ACT_HI = 5;
  localparam int C1_ACT_LO = 4;
  localparam int C1_INIT = 3;
  localparam int C1_POL = 2;
  localparam int C1_SWAP = 1;
  localparam int C1_CCLR = 0;
  // reset values
  localparam logic [7:0] RST_CTL0 = 8'h00;
  localparam logic [7:0] RST_CTL1 = 8'h00;
  localparam logic [9:0] RST_CNT = 10'h000;
  localparam logic [9:0] RST_CMP = 10'h000;
  localparam logic [7:0] RST_HOLD = 8'h00;
  // divider last counts: sys/4, high/16, high/64
  localparam logic [1:0] DIV_SYS_LAST = 2'h3;
  localparam logic [3:0] DIV_H16_LAST = 4'hF;
  localparam logic [5:0] DIV_H64_LAST = 6'h3F;
  // counter top value
  localparam logic [9:0] CNT_TOP = 10'h3FF;
  // clock select codes
  localparam logic [2:0] CLK_SYS4 = 3'h0;
  localparam logic [2:0] CLK_SYS = 3'h1;
  localparam logic [2:0] CLK_H16 = 3'h2;
  localparam logic [2:0] CLK_H64 = 3'h3;
  localparam logic [2:0] CLK_SUB0 = 3'h4;
  localparam logic [2:0] CLK_SUB1 = 3'h5;
  localparam logic [2:0] CLK_EXT_RISE = 3'h6;
  localparam logic [2:0] CLK_EXT_FALL = 3'h7;
  // operating modes
  typedef enum logic [1:0] {
    MODE_CMP = 2'h0, MODE_UNDEF = 2'h1, MODE_PWM = 2'h2, MODE_TMR = 2'h3
  } ctm_mode_t;
  // compare-A output actions
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0, ACT_LOW = 2'h1, ACT_HIGH = 2'h2, ACT_TOGGLE = 2'h3
  } ctm_act_t;
  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ctm_bus_t;
  // whole module state
  typedef struct packed {
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [9:0] cnt;
    logic [9:0] cmp;
    logic [7:0] hold;
    logic [7:0] rdata;
    logic [1:0] div_sys;
    logic [5:0] div_high;
    logic [2:0] ext_sync;
    logic out_lvl;
    logic pin0;
    logic pin1;
    logic irq_a;
    logic irq_p;
  } ctm_state_t;
endpackage
`default_nettype wire

// [verif/compact_timer_module_tb.sv]
// self-checking bench for the compact timer module
`timescale 1ns/100ps
`default_nettype none
module compact_timer_module_tb
  import ctm_pkg::*;
;
  logic clk_sys = 1'b0; // 20 MHz system clock
  logic nrst = 1'b0; // active low reset
  ctm_bus_t bus = '0; // register port request
  logic [7:0] rdata; // read data
  logic tick_high = 1'b0; // high clock enable
  logic tick_sub = 1'b0; // sub clock enable
  logic ext_clk = 1'b0; // external count pin
  logic inv0 = 1'b0; // inversion of pin zero
  logic inv1 = 1'b1; // pin one inverted for a complementary pair
  logic pin0, pin1, irq_a, irq_p; // design outputs
  logic meas = 1'b0; // tick counting window
  int errors = 0, total_checks = 0; // verdict counters
  int n_cyc, n_hi, n_sub, cyc; // ticks seen in the window; cyc counts every cycle
  ctm_top dut_u (.clk_sys_in(clk_sys), .nrst_in(nrst), .bus_in(bus), .rdata_out(rdata),
    .tick_high_in(tick_high), .tick_sub_in(tick_sub), .external_clock_input_in(ext_clk),
    .invert_zero_in(inv0), .invert_one_in(inv1), .timer_output_zero_out(pin0),
    .timer_output_one_out(pin1), .irq_compare_a_out(irq_a), .irq_compare_p_out(irq_p));
  // clock generator
  always #25 clk_sys = ~clk_sys;
  // random tick sources; the pin toggles every 4 cycles so the synchroniser never misses it
  always @(posedge clk_sys) begin
    if (meas) begin
      n_cyc++;
      n_hi += tick_high;
      n_sub += tick_sub;
    end
    cyc++;
    tick_high <= ($urandom % 2) == 0;
    tick_sub <= ($urandom % 8) == 0;
    ext_clk <= cyc[2];
  end
  // verdict and end of run
  task automatic finish_test();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle write
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  // one-cycle read, data taken in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask
  // high byte first, then the buffered low byte
  task automatic rd10(input logic [2:0] hi, output logic [9:0] v);
    logic [7:0] h, l;
    rd(hi, h);
    rd(hi - 3'h1, l);
    v = {h[1:0], l};
  endtask
  // pulse seen on the chosen request line
  function automatic bit hit(bit p);
    return p ? (irq_p === 1'b1) : (irq_a === 1'b1);
  endfunction
  // cycles from a pulse on one line to the next pulse on the same or another line, bounded
  task automatic gap(input bit fa, input bit fb, output int n);
    int i;
    i = 0;
    do begin @(negedge clk_sys); i++; end while (!hit(fa) && i < 3000);
    n = 0;
    do begin @(negedge clk_sys); n++; end while (!hit(fb) && n < 3000);
    if (i >= 3000 || n >= 3000) begin
      errors++;
      finish_test();
    end
  endtask
  // expected count for a clock select code
  function automatic int exp_cnt(int k);
    case (k)
      0: return n_cyc / 4;
      1: return n_cyc;
      2: return n_hi / 16;
      3: return n_hi / 64;
      4, 5: return n_sub;
      default: return n_cyc / 8;
    endcase
  endfunction
  // main sequence
  initial begin
    logic [7:0] x, y, d;
    logic [9:0] v, w;
    logic [2:0] k;
    int n, c, e, lvl;
    logic [2:0] acts [5];
    void'($urandom(29653));
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    // reset values, unmapped offsets read zero
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk(d, 16'h0);
    end
    // paired compare access with random data
    for (int i = 0; i < 4; i++) begin
      x = $urandom;
      y = $urandom;
      wr(OFS_CMPL, x);
      wr(OFS_CMPH, y);
      rd(OFS_CMPH, d);
      chk(d, {14'h0, y[1:0]});
      rd(OFS_CMPL, d);
      chk(d, x);
      wr(OFS_CMPL, ~x);
      rd10(OFS_CMPH, v);
      chk(v, {y[1:0], x});
      rd(OFS_CNTL, d);
      chk(d, x);
    end
    // every clock source, counted over a window then paused
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      wr(OFS_CTL1, 8'hC0);
      wr(OFS_CTL0, {1'b0, k, 4'h0});
      wr(OFS_CTL0, {1'b0, k, 4'h8});
      n_cyc = 0;
      n_hi = 0;
      n_sub = 0;
      meas <= 1'b1;
      repeat (800) @(posedge clk_sys);
      meas <= 1'b0;
      wr(OFS_CTL0, {1'b1, k, 4'h8});
      rd10(OFS_CNTH, v);
      e = exp_cnt(i);
      chk({15'h0, (int'(v) >= e - 3) && (int'(v) <= e + 3)}, 16'h1);
      wr(OFS_CNTL, 8'h55);
      wr(OFS_CNTH, 8'h02);
      repeat (20) @(posedge clk_sys);
      rd10(OFS_CNTH, w);
      chk(w, v);
    end
    // period codes with a random compare value, counter cleared by period match, then by compare A match
    for (int i = 0; i < 8; i++) begin
      c = 1 + $urandom % 100;
      wr(OFS_CMPL, c[7:0]);
      wr(OFS_CMPH, 8'h00);
      wr(OFS_CTL1, 8'hC0);
      wr(OFS_CTL0, {5'h02, i[2:0]});
      wr(OFS_CTL0, {5'h03, i[2:0]});
      gap(1'b1, 1'b1, n);
      chk(n, (i == 0) ? 1024 : i * 128);
      gap(1'b1, 1'b0, n);
      chk(n, c);
      wr(OFS_CTL1, 8'hC1);
      gap(1'b0, 1'b0, n);
      chk(n, c);
    end
    // compare output mode: initial level, then each action with polarity changes
    wr(OFS_CMPL, 8'h14);
    wr(OFS_CMPH, 8'h00);
    // action none first, so the first period's match leaves the level alone
    wr(OFS_CTL1, 8'h08);
    wr(OFS_CTL0, 8'h10);
    wr(OFS_CTL0, 8'h19);
    repeat (3) @(negedge clk_sys);
    chk({pin1, pin0}, 16'h1);
    // leave each action write past the match point of its period
    gap(1'b1, 1'b0, n);
    chk(n, 16'd20);
    lvl = 1;
    acts = '{3'h6, 3'h5, 3'h2, 3'h1, 3'h6};
    for (int i = 0; i < 5; i++) begin
      // fresh port inversion bits for each step
      @(posedge clk_sys);
      inv0 <= i[0];
      inv1 <= 1'($urandom);
      wr(OFS_CTL1, {2'h0, acts[i][2:1], 1'b1, acts[i][0], 2'h0});
      gap(1'b1, 1'b0, n);
      case (acts[i][2:1])
        2'h1: lvl = 0;
        2'h2: lvl = 1;
        2'h3: lvl = 1 - lvl;
        default: lvl = lvl;
      endcase
      repeat (3) @(negedge clk_sys);
      chk(pin0, lvl[0] ^ acts[i][0] ^ inv0);
      chk(pin1, lvl[0] ^ acts[i][0] ^ inv1);
    end
    finish_test();
  end
endmodule
`default_nettype wire
